// file: src/csrb_bank0.v
// Functional notes
// - Core registers mirrored at bank-one addresses
// - No direct access to upper PC
// - Low PC write loads PC high
// - Unimplemented locations read zero
// - Power-on loads full reset values
// - Pin and watchdog resets keep TIMER0, PTR, T1, SBUF, CCL/CCH, ADR, port B/C; others clear or part-clear
// - Every reset makes port A input
// - Port B/C reset is latch value
// - Registers are static storage
// - Bank select picks active bank
// - Indirect window accesses pointer target
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "csrb_regs.vh"
module csrb_bank0 #(
  parameter HAS_ADC = 1
) (
  input wire ref_clk,
  input wire reset,
  input wire por_reset,
  input wire [6:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [7:0] bus_rdata,
  input wire [5:0] port_a_pins,
  input wire [7:0] port_b_pins,
  input wire [7:0] port_c_pins,
  output wire [5:0] port_a_latch,
  output wire [7:0] port_b_latch,
  output wire [7:0] port_c_latch,
  output wire port_a_force_input,
  output wire [12:0] pc_out,
  output wire [1:0] bank_select,
  output wire bank_valid,
  input wire [7:0] ext_rdata
);
  // ****************
  // Storage
  // ****************
  // static flops, no refresh
  reg [7:0] timer0_count_q, pcl_q, stat_q, ptr_q, intc_q, pirq_q;
  reg [7:0] t1l_q, t1h_q, t1c_q, t2_q, t2c_q, sbuf_q, scon_q;
  reg [7:0] ccl_q, cch_q, ccc_q, adr_q, adc_q;
  reg [5:0] pa_q;
  reg [7:0] pb_q, pc_q;
  reg [4:0] pch_q, pcu_q;
  reg pa_in_q;
  reg [5:0] pa_s1_q, pa_s2_q;
  reg [7:0] pb_s1_q, pb_s2_q, pc_s1_q, pc_s2_q;

  // ****************
  // Address resolution
  // ****************
  // window uses pointer target
  wire ind = (bus_addr == `CSRB_A_INDWIN);
  wire [6:0] eff_addr = ind ? ptr_q[6:0] : bus_addr;
  assign bank_select = {stat_q[`CSRB_ST_BSH_BIT], stat_q[`CSRB_ST_BSL_BIT]};
  assign bank_valid = (bank_select[1] == 1'b0);
  wire [1:0] eff_bank = ind ? {1'b0, ptr_q[7]} : bank_select;
  // core regs answer in every bank
  function is_core;
    input [6:0] a;
    begin
      is_core = (a == `CSRB_A_PCL) || (a == `CSRB_A_STAT) || (a == `CSRB_A_PTR) ||
                (a == `CSRB_A_PCH) || (a == `CSRB_A_INTC);
    end
  endfunction
  // Core regs must stay reachable even from an unimplemented bank
  wire hit = (eff_bank[1] == 1'b0) || is_core(eff_addr);
  wire wr = bus_wr && hit && !(ind && ptr_q[6:0] == `CSRB_A_INDWIN);
  function adc_ok;
    input dummy;
    begin
      adc_ok = (HAS_ADC != 0);
    end
  endfunction

  // ****************
  // Write and reset
  // ****************
  always @(posedge ref_clk) begin
    if (reset) begin
      if (por_reset) begin
        stat_q <= `CSRB_RST_STAT_POR;
        ptr_q <= `CSRB_RST_ZERO;
        timer0_count_q <= `CSRB_RST_ZERO;
        pb_q <= `CSRB_RST_ZERO;
        pc_q <= `CSRB_RST_ZERO;
        pa_q <= 6'h00;
        intc_q <= `CSRB_RST_ZERO;
        t1l_q <= `CSRB_RST_ZERO;
        t1h_q <= `CSRB_RST_ZERO;
        t1c_q <= `CSRB_RST_ZERO;
        sbuf_q <= `CSRB_RST_ZERO;
        ccl_q <= `CSRB_RST_ZERO;
        cch_q <= `CSRB_RST_ZERO;
        adr_q <= `CSRB_RST_ZERO;
      end else begin
        stat_q <= {3'b000, 2'b00, stat_q[2:0]};
        intc_q <= {7'h00, intc_q[0]};
        pa_q <= {1'b0, pa_q[4], 4'h0};
      end
      pcl_q <= `CSRB_RST_ZERO;
      pch_q <= `CSRB_RST_PCH;
      pcu_q <= `CSRB_RST_PCH;
      pirq_q <= `CSRB_RST_ZERO;
      t2_q <= `CSRB_RST_ZERO;
      t2c_q <= `CSRB_RST_ZERO;
      scon_q <= `CSRB_RST_ZERO;
      ccc_q <= `CSRB_RST_ZERO;
      adc_q <= `CSRB_RST_ZERO;
      pa_in_q <= 1'b1;
    end else if (wr) begin
      if (eff_addr == `CSRB_A_TIMER0_COUNT && eff_bank == 2'b00) begin
        timer0_count_q <= bus_wdata;
      end else if (eff_addr == `CSRB_A_PCL) begin
        pcl_q <= bus_wdata;
        pcu_q <= pch_q;
      end else if (eff_addr == `CSRB_A_STAT) begin
        stat_q <= {bus_wdata[7:5], stat_q[4:3], bus_wdata[2:0]};
      end else if (eff_addr == `CSRB_A_PTR) begin
        ptr_q <= bus_wdata;
      end else if (eff_addr == `CSRB_A_PCH) begin
        pch_q <= bus_wdata[4:0];
      end else if (eff_addr == `CSRB_A_INTC) begin
        intc_q <= bus_wdata;
      end else if (eff_bank == 2'b00) begin
        if (eff_addr == `CSRB_A_PA) begin
          pa_q <= bus_wdata[5:0];
          pa_in_q <= 1'b0;
        end else if (eff_addr == `CSRB_A_PB) begin
          pb_q <= bus_wdata;
        end else if (eff_addr == `CSRB_A_PC) begin
          pc_q <= bus_wdata;
        end else if (eff_addr == `CSRB_A_PIRQ) begin
          pirq_q <= bus_wdata & (adc_ok(1'b0) ? `CSRB_PIRQ_MASK :
                    (`CSRB_PIRQ_MASK & ~`CSRB_PIRQ_ADC_MASK));
        end else if (eff_addr == `CSRB_A_T1L) begin
          t1l_q <= bus_wdata;
        end else if (eff_addr == `CSRB_A_T1H) begin
          t1h_q <= bus_wdata;
        end else if (eff_addr == `CSRB_A_T1C) begin
          t1c_q <= bus_wdata & `CSRB_T1C_MASK;
        end else if (eff_addr == `CSRB_A_T2) begin
          t2_q <= bus_wdata;
        end else if (eff_addr == `CSRB_A_T2C) begin
          t2c_q <= bus_wdata & `CSRB_T2C_MASK;
        end else if (eff_addr == `CSRB_A_SBUF) begin
          sbuf_q <= bus_wdata;
        end else if (eff_addr == `CSRB_A_SCON) begin
          scon_q <= bus_wdata;
        end else if (eff_addr == `CSRB_A_CCL) begin
          ccl_q <= bus_wdata;
        end else if (eff_addr == `CSRB_A_CCH) begin
          cch_q <= bus_wdata;
        end else if (eff_addr == `CSRB_A_CCC) begin
          ccc_q <= bus_wdata & `CSRB_CCC_MASK;
        end else if (eff_addr == `CSRB_A_ADR && adc_ok(1'b0)) begin
          adr_q <= bus_wdata;
        end else if (eff_addr == `CSRB_A_ADC && adc_ok(1'b0)) begin
          adc_q <= bus_wdata & `CSRB_ADC_MASK;
        end
      end
    end
  end

  // ****************
  // Pin synchronisers
  // ****************
  always @(posedge ref_clk) begin
    if (reset) begin
      pa_s1_q <= 6'h00;
      pa_s2_q <= 6'h00;
      pb_s1_q <= 8'h00;
      pb_s2_q <= 8'h00;
      pc_s1_q <= 8'h00;
      pc_s2_q <= 8'h00;
    end else begin
      pa_s1_q <= port_a_pins;
      pa_s2_q <= pa_s1_q;
      pb_s1_q <= port_b_pins;
      pb_s2_q <= pb_s1_q;
      pc_s1_q <= port_c_pins;
      pc_s2_q <= pc_s1_q;
    end
  end

  // ****************
  // Read path
  // ****************
  reg [7:0] rd_d;
  always @* begin
    rd_d = 8'h00;
    if (!hit || (ind && ptr_q[6:0] == `CSRB_A_INDWIN)) begin
      rd_d = 8'h00;
    end else if (eff_addr == `CSRB_A_PCL) begin
      rd_d = pcl_q;
    end else if (eff_addr == `CSRB_A_STAT) begin
      rd_d = stat_q;
    end else if (eff_addr == `CSRB_A_PTR) begin
      rd_d = ptr_q;
    end else if (eff_addr == `CSRB_A_PCH) begin
      rd_d = {3'b000, pch_q};
    end else if (eff_addr == `CSRB_A_INTC) begin
      rd_d = intc_q;
    end else if (eff_bank != 2'b00) begin
      rd_d = ext_rdata;
    end else if (eff_addr == `CSRB_A_TIMER0_COUNT) begin
      rd_d = timer0_count_q;
    end else if (eff_addr == `CSRB_A_PA) begin
      rd_d = {2'b00, pa_s2_q};
    end else if (eff_addr == `CSRB_A_PB) begin
      rd_d = pb_s2_q;
    end else if (eff_addr == `CSRB_A_PC) begin
      rd_d = pc_s2_q;
    end else if (eff_addr == `CSRB_A_PIRQ) begin
      rd_d = pirq_q;
    end else if (eff_addr == `CSRB_A_T1L) begin
      rd_d = t1l_q;
    end else if (eff_addr == `CSRB_A_T1H) begin
      rd_d = t1h_q;
    end else if (eff_addr == `CSRB_A_T1C) begin
      rd_d = t1c_q;
    end else if (eff_addr == `CSRB_A_T2) begin
      rd_d = t2_q;
    end else if (eff_addr == `CSRB_A_T2C) begin
      rd_d = t2c_q;
    end else if (eff_addr == `CSRB_A_SBUF) begin
      rd_d = sbuf_q;
    end else if (eff_addr == `CSRB_A_SCON) begin
      rd_d = scon_q;
    end else if (eff_addr == `CSRB_A_CCL) begin
      rd_d = ccl_q;
    end else if (eff_addr == `CSRB_A_CCH) begin
      rd_d = cch_q;
    end else if (eff_addr == `CSRB_A_CCC) begin
      rd_d = ccc_q;
    end else if (eff_addr == `CSRB_A_ADR) begin
      rd_d = adr_q;
    end else if (eff_addr == `CSRB_A_ADC) begin
      rd_d = adc_q;
    end else if (eff_addr >= 7'h20) begin
      rd_d = ext_rdata;
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      bus_rdata <= rd_d;
    end else begin
      bus_rdata <= 8'h00;
    end
  end

  assign port_a_latch = pa_q;
  assign port_b_latch = pb_q;
  assign port_c_latch = pc_q;
  assign port_a_force_input = pa_in_q;
  assign pc_out = {pcu_q, pcl_q};
endmodule // csrb_bank0

// file: src/csrb_regs.vh
`ifndef CSRB_REGS_VH
`define CSRB_REGS_VH
// ****************
// Register offsets
// ****************
`define CSRB_A_INDWIN 7'h00
`define CSRB_A_TIMER0_COUNT 7'h01
`define CSRB_A_PCL 7'h02
`define CSRB_A_STAT 7'h03
`define CSRB_A_PTR 7'h04
`define CSRB_A_PA 7'h05
`define CSRB_A_PB 7'h06
`define CSRB_A_PC 7'h07
`define CSRB_A_PCH 7'h0a
`define CSRB_A_INTC 7'h0b
`define CSRB_A_PIRQ 7'h0c
`define CSRB_A_T1L 7'h0e
`define CSRB_A_T1H 7'h0f
`define CSRB_A_T1C 7'h10
`define CSRB_A_T2 7'h11
`define CSRB_A_T2C 7'h12
`define CSRB_A_SBUF 7'h13
`define CSRB_A_SCON 7'h14
`define CSRB_A_CCL 7'h15
`define CSRB_A_CCH 7'h16
`define CSRB_A_CCC 7'h17
`define CSRB_A_ADR 7'h1e
`define CSRB_A_ADC 7'h1f
`define CSRB_BANK1_BASE 8'h80
// ****************
// Field positions and masks
// ****************
`define CSRB_ST_IND_BIT 7
`define CSRB_ST_BSH_BIT 6
`define CSRB_ST_BSL_BIT 5
`define CSRB_ST_TO_BIT 4
`define CSRB_ST_PD_BIT 3
`define CSRB_PIRQ_MASK 8'h4f
`define CSRB_PIRQ_ADC_MASK 8'h40
`define CSRB_T1C_MASK 8'h3f
`define CSRB_T2C_MASK 8'h7f
`define CSRB_CCC_MASK 8'h3f
`define CSRB_ADC_MASK 8'hfd
`define CSRB_PA_MASK 8'h3f
// ****************
// Reset values
// ****************
`define CSRB_RST_ZERO 8'h00
`define CSRB_RST_STAT_POR 8'h18
`define CSRB_RST_PCH 5'h00
`endif

// file: sim/csrb_bank0_properties.sv
`timescale 1ns/1ps
// ****************
// Port checker
// ****************
module csrb_bank0_properties (
  input wire ref_clk,
  input wire reset,
  input wire [6:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  input wire [7:0] bus_rdata,
  input wire [5:0] port_a_latch,
  input wire [7:0] port_b_latch,
  input wire port_a_force_input,
  input wire [12:0] pc_out,
  input wire [1:0] bank_select,
  input wire bank_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire b0 = bank_select == 2'b00;
  wire pcl_wr = bus_wr && bus_addr == 7'h02;
  wire gap = bus_addr inside {7'h08, 7'h09, 7'h0d} || (bus_addr >= 7'h18 && bus_addr <= 7'h1d);
  a_pc_low_load: assert property (pcl_wr |=> pc_out[7:0] == $past(bus_wdata))
    else $error("pc low byte not loaded");
  a_pc_high_hold: assert property (!pcl_wr |=> $stable(pc_out[12:8]))
    else $error("pc upper bits moved without low byte write");
  a_gap_reads_zero: assert property (bus_rd && b0 && gap |=> bus_rdata == 8'h00)
    else $error("unimplemented location read nonzero");
  a_bank_code_valid: assert property (bank_valid == !bank_select[1])
    else $error("bank valid flag wrong");
  a_reset_port_input: assert property ($past(reset) |-> port_a_force_input)
    else $error("port a not input after reset");
  a_port_a_write: assert property (bus_wr && bus_addr == 7'h05 && b0
    |=> port_a_latch == $past(bus_wdata[5:0]))
    else $error("port a latch not written");
  a_port_b_hold: assert property (!(bus_wr && bus_addr == 7'h06 && b0)
    |=> $stable(port_b_latch))
    else $error("port b latch changed");
  a_status_mirror: assert property (bus_rd && bus_addr == 7'h03
    |=> bus_rdata[6:5] == $past(bank_select))
    else $error("status read wrong bank bits");
  cover property (pcl_wr);
  cover property (bus_rd && bus_addr == 7'h03 && !b0);
  cover property (bus_wr && bus_addr == 7'h05 && b0);
endmodule // csrb_bank0_properties

bind csrb_bank0 csrb_bank0_properties u_props (.ref_clk(ref_clk), .reset(reset),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .port_a_latch(port_a_latch), .port_b_latch(port_b_latch),
  .port_a_force_input(port_a_force_input), .pc_out(pc_out),
  .bank_select(bank_select), .bank_valid(bank_valid));

// file: sim/csrb_bank0_tb.sv
`timescale 1ns/1ps
module csrb_bank0_tb;
  reg ref_clk = 1'b0;
  reg reset = 1'b1;
  reg por_reset = 1'b1;
  reg [6:0] bus_addr = 7'h00;
  reg [7:0] bus_wdata = 8'h00;
  reg bus_wr = 1'b0;
  reg bus_rd = 1'b0;
  reg [5:0] pa_pins = 6'h00;
  reg [7:0] pb_pins = 8'h00;
  reg [7:0] pc_pins = 8'h00;
  reg [7:0] ext_rdata = 8'h00;
  wire [7:0] bus_rdata;
  wire [5:0] pa_lat;
  wire [7:0] pb_lat;
  wire force_in;
  wire [12:0] pc_out;
  wire [1:0] bsel;
  wire bvalid;
  int miscompares = 0;
  int checks = 0;
  int m[0:31];
  logic [31:0] seed = 32'h36879297;
  logic [7:0] v;
  logic [7:0] ms;
  logic [7:0] pbv;
  logic [4:0] r5;
  logic [6:0] ra[16] = '{7'h01, 7'h04, 7'h0b, 7'h0c, 7'h0e, 7'h0f, 7'h10, 7'h11,
    7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h1e, 7'h1f};
  logic [7:0] rm[16] = '{8'hff, 8'hff, 8'hff, 8'h4f, 8'hff, 8'hff, 8'h3f, 8'hff,
    8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hfd};
  logic [6:0] ua[9] = '{7'h08, 7'h09, 7'h0d, 7'h18, 7'h19, 7'h1a, 7'h1b, 7'h1c, 7'h1d};

  csrb_bank0 DUT (.ref_clk(ref_clk), .reset(reset), .por_reset(por_reset),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .port_a_pins(pa_pins), .port_b_pins(pb_pins),
    .port_c_pins(pc_pins), .port_a_latch(pa_lat), .port_b_latch(pb_lat),
    .port_c_latch(), .port_a_force_input(force_in), .pc_out(pc_out),
    .bank_select(bsel), .bank_valid(bvalid), .ext_rdata(ext_rdata));

  always #5 ref_clk = ~ref_clk;

  // ****************
  // Bus tasks and model
  // ****************
  function logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function bit zr(input logic [6:0] a);
    return a inside {7'h0c, 7'h10, 7'h11, 7'h12, 7'h14, 7'h17, 7'h1f};
  endfunction
  task eq(input logic [12:0] g, input logic [12:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task rd(input logic [6:0] a, input logic [7:0] e);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1;
    eq(bus_rdata, e);
    @(posedge ref_clk);
  endtask
  // After power-on only the zr registers are read, though power-on reset zeroes the others as well
  task chk_all(input bit por);
    for (int k = 0; k < 16; k++) if (!por || zr(ra[k])) rd(ra[k], m[ra[k]]);
  endtask
  task rst(input bit por, input int n);
    por_reset <= por;
    reset <= 1'b1;
    repeat (n) @(posedge ref_clk);
    reset <= 1'b0;
    for (int k = 0; k < 16; k++) if (zr(ra[k]) && (por || ra[k] != 7'h10)) m[ra[k]] = 0;
    m[7'h0b] = m[7'h0b] & 1;
    m[7'h0a] = 0;
    ms = por ? 8'h18 : ms & 8'h07;
    @(posedge ref_clk);
  endtask
  task conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  initial begin
    rst(1'b1, 12);
    eq(force_in, 1'b1);
    eq(pc_out, 13'h0000);
    rd(7'h03, ms);
    chk_all(1'b1);
    $display("test reset values done");
    for (int k = 0; k < 16; k++) begin
      v = rnd();
      wr(ra[k], v);
      m[ra[k]] = v & rm[k];
    end
    for (int k = 0; k < 9; k++) begin
      wr(ua[k], rnd());
      rd(ua[k], 8'h00);
    end
    chk_all(1'b0);
    $display("test storage done");
    r5 = rnd();
    wr(7'h0a, r5);
    m[7'h0a] = r5;
    eq(pc_out, 13'h0000);
    v = rnd();
    wr(7'h02, v);
    eq(pc_out, {r5, v});
    rd(7'h02, v);
    $display("test pc load done");
    wr(7'h03, 8'h20);
    eq(bsel, 2'b01);
    rd(7'h0a, r5);
    ext_rdata <= rnd();
    @(posedge ref_clk);
    rd(7'h05, ext_rdata);
    v = rnd();
    wr(7'h0b, v);
    m[7'h0b] = v;
    wr(7'h03, 8'h40);
    eq(bvalid, 1'b0);
    wr(7'h03, 8'h07);
    ms = 8'h1f;
    rd(7'h03, ms);
    rd(7'h0b, v);
    $display("test banks done");
    wr(7'h04, 8'h11);
    m[7'h04] = 8'h11;
    v = rnd();
    wr(7'h00, v);
    m[7'h11] = v;
    rd(7'h11, v);
    rd(7'h00, v);
    $display("test indirect done");
    pbv = rnd();
    wr(7'h06, pbv);
    eq(pb_lat, pbv);
    pa_pins <= rnd();
    pb_pins <= rnd();
    pc_pins <= rnd();
    repeat (3) @(posedge ref_clk);
    rd(7'h05, pa_pins);
    rd(7'h06, pb_pins);
    rd(7'h07, pc_pins);
    v = rnd();
    wr(7'h05, v);
    eq(pa_lat, v[5:0]);
    eq(force_in, 1'b0);
    $display("test ports done");
    rst(1'b0, 2);
    eq(force_in, 1'b1);
    eq(pb_lat, pbv);
    eq(pa_lat, {1'b0, v[4], 4'h0});
    eq(pc_out, 13'h0000);
    rd(7'h03, ms);
    chk_all(1'b0);
    $display("test pin reset done");
    rst(1'b1, 2);
    rd(7'h03, ms);
    chk_all(1'b1);
    $display("test power reset done");
    conclude();
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    conclude();
  end
endmodule // csrb_bank0_tb
